// [epi_pin_if.sv]
// Synchronised pin levels and change strobes between the pin stage and the unit
`timescale 1ns/1ps
`default_nettype none

interface epi_pin_if #(parameter int W = 1);
	logic [W-1:0] level;
	logic [W-1:0] change;

	modport src (output level, output change);
	modport dst (input level, input change);
endinterface : epi_pin_if

`default_nettype wire

// [epi_pin_sync.sv]
// Two-flop pin synchroniser with change detection on the sampled value
`timescale 1ns/1ps
`default_nettype none

module epi_pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// Raw pins and detector gate
	input  wire logic [W-1:0] pin_raw,
	input  wire logic         detect_en,
	// Sampled result
	epi_pin_if.src            pins
);

	logic [W-1:0] sync_a;
	logic [W-1:0] sync_b;
	logic [W-1:0] prev;

	// ==========================================================
	// Sampling
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= pin_raw;
			sync_b <= sync_a;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev <= '0;
		end else begin
			prev <= sync_b;
		end
	end

	// ==========================================================
	// Change strobe, one cycle per toggle of the sampled level
	assign pins.level  = sync_b;
	assign pins.change = detect_en ? (sync_b ^ prev) : '0;

endmodule : epi_pin_sync

`default_nettype wire

// [epi_pkg.sv]
// Shared constants of the external pin interrupt unit
package epi_pkg;

	// ==========================================================
	// Sizes
	localparam int NUM_PC  = 31;
	localparam int GRP_W   = 8;
	localparam int NUM_GRP = 4;
	localparam int NUM_REQ = NUM_GRP + 1;

	// ==========================================================
	// Register byte offsets (low address byte)
	localparam logic [7:0] OFS_SENSE  = 8'h00;
	localparam logic [7:0] OFS_ENABLE = 8'h04;
	localparam logic [7:0] OFS_FLAG   = 8'h08;
	localparam logic [7:0] OFS_MASK0  = 8'h0c;
	localparam logic [7:0] OFS_MASK1  = 8'h10;
	localparam logic [7:0] OFS_MASK2  = 8'h14;
	localparam logic [7:0] OFS_MASK3  = 8'h18;
	localparam logic [7:0] OFS_PINS   = 8'h1c;

	// ==========================================================
	// Field layout of the enable, flag and sense registers
	localparam int BIT_DED     = 0;
	localparam int BIT_GRP_LSB = 4;
	localparam int SENSE_W     = 2;

	// Request vector index: dedicated pin first, then groups
	localparam int REQ_DED = 0;

	// ==========================================================
	// Sense control encodings
	localparam logic [1:0] SENSE_LOW  = 2'b00;
	localparam logic [1:0] SENSE_ANY  = 2'b01;
	localparam logic [1:0] SENSE_FALL = 2'b10;
	localparam logic [1:0] SENSE_RISE = 2'b11;

	// ==========================================================
	// Reset values and the implemented bits of mask 3
	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic [7:0] MASK3_USED = 8'h7f;

	// ==========================================================
	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic       HRESP_OKAY    = 1'b0;

endpackage : epi_pkg

// [epi_src_model.sv]
// Model of the external sources driving the interrupt pins
`timescale 1ns/1ps
`default_nettype none

module epi_src_model
	import epi_pkg::*;
(
	// Clock
	input wire logic	hclk,
	// Pins
	output var logic	ded,
	output var logic [NUM_PC-1:0]	pc
);
	initial begin
		ded = 1'b1;
		pc = '0;
	end

	// Port written as output still reaches the input path; level held many cycles
	task automatic flip(input int i);
		@(posedge hclk);
		pc[i] <= ~pc[i];
	endtask : flip

	// Level is held through start-up and the running instruction
	task automatic lvl(input logic v);
		@(posedge hclk);
		ded <= v;
	endtask : lvl
endmodule : epi_src_model

`default_nettype wire

// [epi_unit.sv]
// External pin interrupt unit: dedicated pin, pin-change groups, AHB-Lite registers
//
// Behaviour
// [RULE1] Pin activity counts even when pin drives out
// [RULE2] Group one fires on enabled inputs 15..8
// [RULE3] Group zero fires on enabled inputs 7..0
// [RULE4] Per-group masks select contributing pins
// [RULE5] Pin-change wake works without I/O clock
// [RULE6] Sense field: low, any, falling, rising
// [RULE7] Low level requests while pin stays low
// [RULE8] Edge modes run on the I/O clock
// [RULE9] Low-level wake detection is asynchronous
// [RULE10] I/O clock stops in sleep except Idle
// [RULE11] Source holds wake level through start-up
// [RULE12] Short wake level gives no interrupt
// [RULE13] Dedicated request needs global and own enable
// [RULE14] Edges detected on sampled pin value
// [RULE15] Pulses over one clock period are caught
// [RULE16] Source holds low until instruction completes
// [RULE17] Trigger sets flag; handler or one clears
// [RULE18] Dedicated flag reads zero in level mode
// [RULE19] Group request combines mask with group enable
//
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module epi_unit
	import epi_pkg::*;
(
	// Clock and reset
	input  wire logic                hclk,
	input  wire logic                hresetn,
	// AHB-Lite slave
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic                hready,
	input  wire logic [31:0]         hwdata,
	output logic                     hreadyout,
	output logic                     hresp,
	output logic [31:0]              hrdata,
	// External pins, sampled whatever their direction
	input  wire logic                dedicated_irq_pin,
	input  wire logic [NUM_PC-1:0]   pin_change_inputs,
	// Processor interrupt logic
	input  wire logic                global_irq_en,
	input  wire logic [NUM_REQ-1:0]  irq_ack,
	output logic [NUM_REQ-1:0]       irq_req,
	output logic                     irq,
	// Power management
	input  wire logic                sleep_active,
	input  wire logic                sleep_idle,
	input  wire logic                startup_done,
	output logic                     wake_req
);

	// ==========================================================
	// Register layout helpers
	function automatic logic [7:0] pack_bits(input logic [NUM_REQ-1:0] v);
		logic [7:0] r;
		r = RST_BYTE;
		r[BIT_DED] = v[REQ_DED];
		r[BIT_GRP_LSB +: NUM_GRP] = v[NUM_REQ-1:1];
		return r;
	endfunction : pack_bits

	function automatic logic [NUM_REQ-1:0] unpack_bits(input logic [7:0] b);
		return {b[BIT_GRP_LSB +: NUM_GRP], b[BIT_DED]};
	endfunction : unpack_bits

	// ==========================================================
	// State
	logic [SENSE_W-1:0]          sense_sel;
	logic [NUM_REQ-1:0]          enable;
	logic [NUM_REQ-1:0]          flag;
	logic [NUM_REQ-1:0]          next_flag;
	logic [GRP_W-1:0]            pcmask [NUM_GRP];
	logic [NUM_REQ-1:0]          set_ev;
	logic [NUM_REQ-1:0]          clr_sw;
	logic                        wr_pend;
	logic [7:0]                  wr_addr;
	logic                        addr_ok;
	logic                        io_run;
	logic                        level_mode;
	logic                        level_req;
	logic                        ded_edge;
	logic [NUM_GRP*GRP_W-1:0]    pc_change_ext;
	logic [NUM_GRP*GRP_W-1:0]    pc_delta_raw;
	logic [NUM_GRP-1:0]          grp_hit;
	logic [NUM_GRP-1:0]          grp_wake;
	logic [31:0]                 rd_mux;

	epi_pin_if #(.W(1))      ded_if ();
	epi_pin_if #(.W(NUM_PC)) pc_if ();

	// ==========================================================
	// I/O clock model: the dedicated pin edge detector runs only outside deep sleep
	assign io_run = !sleep_active || sleep_idle;  // [RULE10] [RULE8]

	// ==========================================================
	// Pin sampling
	epi_pin_sync #(.W(1)) u_ded_sync (  // [RULE14] [RULE1]
		.hclk      (hclk),
		.hresetn   (hresetn),
		.pin_raw   (dedicated_irq_pin),
		.detect_en (io_run),
		.pins      (ded_if.src)
	);

	epi_pin_sync #(.W(NUM_PC)) u_pc_sync (  // [RULE1]
		.hclk      (hclk),
		.hresetn   (hresetn),
		.pin_raw   (pin_change_inputs),
		.detect_en (1'b1),
		.pins      (pc_if.src)
	);

	// ==========================================================
	// Dedicated pin trigger selection
	assign level_mode = (sense_sel == SENSE_LOW);

	always_comb begin
		case (sense_sel)  // [RULE6]
			SENSE_ANY:  ded_edge = ded_if.change[0];  // [RULE15]
			SENSE_FALL: ded_edge = ded_if.change[0] && !ded_if.level[0];
			SENSE_RISE: ded_edge = ded_if.change[0] && ded_if.level[0];
			default:    ded_edge = 1'b0;
		endcase
	end

	// Level request lasts while the sampled pin is low once wake-up is done
	assign level_req = level_mode && !ded_if.level[0] && startup_done;  // [RULE7] [RULE12]

	// ==========================================================
	// Pin-change groups
	assign pc_change_ext = {{(NUM_GRP*GRP_W-NUM_PC){1'b0}}, pc_if.change};
	assign pc_delta_raw  = {{(NUM_GRP*GRP_W-NUM_PC){1'b0}}, pin_change_inputs ^ pc_if.level};

	generate
		for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
			// Group g covers inputs 8g+7..8g; masked pins never contribute
			assign grp_hit[g]  = |(pc_change_ext[g*GRP_W +: GRP_W] & pcmask[g]);  // [RULE2] [RULE3] [RULE4]
			// Raw input against last sampled level, live without any clock
			assign grp_wake[g] = enable[g+1] && |(pc_delta_raw[g*GRP_W +: GRP_W] & pcmask[g]);  // [RULE5]
		end
	endgenerate

	// ==========================================================
	// Wake-up toward power management, asynchronous paths only
	assign wake_req = sleep_active && (
		(level_mode && enable[REQ_DED] && !dedicated_irq_pin) ||  // [RULE9]
		(|grp_wake));  // [RULE5]

	// ==========================================================
	// Flags: event set wins over handler or software clear
	assign set_ev = {grp_hit, ded_edge};  // [RULE17]

	always_comb begin
		next_flag = (flag & ~(clr_sw | irq_ack)) | set_ev;  // [RULE17]
		if (level_mode) begin
			next_flag[REQ_DED] = 1'b0;  // [RULE18]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag <= '0;
		end else begin
			flag <= next_flag;
		end
	end

	// ==========================================================
	// Requests toward the processor
	always_comb begin
		irq_req = {NUM_REQ{global_irq_en}} & enable & flag;  // [RULE19]
		irq_req[REQ_DED] = global_irq_en && enable[REQ_DED] &&
			(level_mode ? level_req : flag[REQ_DED]);  // [RULE13] [RULE7]
	end

	assign irq = |irq_req;

	// ==========================================================
	// AHB-Lite address phase
	assign hreadyout = 1'b1;
	assign hresp     = HRESP_OKAY;
	assign addr_ok   = hsel && hready && (htrans == HTRANS_NONSEQ);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= RST_BYTE;
		end else begin
			wr_pend <= addr_ok && hwrite;
			wr_addr <= haddr[7:0];
		end
	end

	// ==========================================================
	// Register writes in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sense_sel <= SENSE_LOW;
			enable    <= '0;
			for (int i = 0; i < NUM_GRP; i++) begin
				pcmask[i] <= RST_BYTE;
			end
		end else if (wr_pend) begin
			case (wr_addr)
				OFS_SENSE:  sense_sel <= hwdata[SENSE_W-1:0];  // [RULE6]
				OFS_ENABLE: enable    <= unpack_bits(hwdata[7:0]);
				OFS_MASK0:  pcmask[0] <= hwdata[GRP_W-1:0];  // [RULE4]
				OFS_MASK1:  pcmask[1] <= hwdata[GRP_W-1:0];
				OFS_MASK2:  pcmask[2] <= hwdata[GRP_W-1:0];
				OFS_MASK3:  pcmask[3] <= hwdata[GRP_W-1:0] & MASK3_USED;
				default: begin
				end
			endcase
		end
	end

	// Write-one-to-clear strobe for the flag register
	always_comb begin
		clr_sw = '0;
		if (wr_pend && (wr_addr == OFS_FLAG)) begin
			clr_sw = unpack_bits(hwdata[7:0]);  // [RULE17]
		end
	end

	// ==========================================================
	// Register reads, data registered at the address phase
	always_comb begin
		rd_mux = '0;
		case (haddr[7:0])
			OFS_SENSE:  rd_mux[SENSE_W-1:0] = sense_sel;
			OFS_ENABLE: rd_mux[7:0] = pack_bits(enable);
			OFS_FLAG:   rd_mux[7:0] = pack_bits(flag);  // [RULE18]
			OFS_MASK0:  rd_mux[GRP_W-1:0] = pcmask[0];
			OFS_MASK1:  rd_mux[GRP_W-1:0] = pcmask[1];
			OFS_MASK2:  rd_mux[GRP_W-1:0] = pcmask[2];
			OFS_MASK3:  rd_mux[GRP_W-1:0] = pcmask[3];
			OFS_PINS:   rd_mux = {ded_if.level, pc_if.level};
			default:    rd_mux = '0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (addr_ok && !hwrite) begin
			hrdata <= rd_mux;
		end
	end

endmodule : epi_unit

`default_nettype wire

// [epi_unit_monitor.sv]
// Assertion checker bound to the external pin interrupt unit
`timescale 1ns/1ps
`default_nettype none

module epi_unit_monitor
	import epi_pkg::*;
(
	// Bus
	input wire logic	hclk,
	input wire logic	hresetn,
	input wire logic	hsel,
	input wire logic [31:0]	haddr,
	input wire logic [1:0]	htrans,
	input wire logic	hwrite,
	input wire logic	hready,
	input wire logic [31:0]	hwdata,
	// Pins and requests
	input wire logic	dedicated_irq_pin,
	input wire logic [NUM_PC-1:0]	pin_change_inputs,
	input wire logic	global_irq_en,
	input wire logic [NUM_REQ-1:0]	irq_ack,
	input wire logic [NUM_REQ-1:0]	irq_req,
	input wire logic	irq,
	input wire logic	sleep_active,
	input wire logic	startup_done,
	input wire logic	wake_req
);
	logic	wp;
	logic [7:0]	wa;
	logic [1:0]	sense_q;
	logic [7:0]	en_q;

	// ==========================================================
	// Shadow of sense and enable writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp <= 1'b0;
			wa <= 8'h00;
			sense_q <= SENSE_LOW;
			en_q <= 8'h00;
		end else if (hready) begin
			wp <= hsel && hwrite && htrans == HTRANS_NONSEQ;
			wa <= haddr[7:0];
			if (wp && wa == OFS_SENSE) sense_q <= hwdata[1:0];
			if (wp && wa == OFS_ENABLE) en_q <= hwdata[7:0];
		end
	end

	// ==========================================================
	// Properties
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_or; irq == (|irq_req); endproperty
	a_or: assert property (p_or) else $error("irq differs from request or");
	property p_gie; !global_irq_en |-> irq_req == '0; endproperty
	a_gie: assert property (p_gie) else $error("request without global enable");
	property p_dis; !en_q[REQ_DED] |-> !irq_req[REQ_DED]; endproperty
	a_dis: assert property (p_dis) else $error("pin request while disabled");
	property p_grp; en_q[7:4] == 4'h0 |-> irq_req[NUM_REQ-1:1] == 4'h0; endproperty
	a_grp: assert property (p_grp) else $error("group request while disabled");
	property p_lvl;
		(sense_q == SENSE_LOW && en_q[REQ_DED] && global_irq_en && startup_done && !dedicated_irq_pin)[*4]
		|-> irq_req[REQ_DED];
	endproperty
	a_lvl: assert property (p_lvl) else $error("low level gives no request");
	property p_lvl_off; (sense_q == SENSE_LOW && dedicated_irq_pin)[*3] |-> !irq_req[REQ_DED]; endproperty
	a_lvl_off: assert property (p_lvl_off) else $error("level mode request with pin high");
	property p_rise;
		sense_q == SENSE_RISE && en_q[REQ_DED] && global_irq_en && !sleep_active && $rose(dedicated_irq_pin)
		|-> ##[1:4] irq_req[REQ_DED];
	endproperty
	a_rise: assert property (p_rise) else $error("rising edge missed");
	property p_ack; $stable(pin_change_inputs)[*4] ##0 irq_ack[2] |=> !irq_req[2]; endproperty
	a_ack: assert property (p_ack) else $error("ack left request set");
	property p_wake;
		sleep_active && sense_q == SENSE_LOW && en_q[REQ_DED] && global_irq_en && !dedicated_irq_pin |-> wake_req;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on low level");

	c_lvl: cover property (sense_q == SENSE_LOW && irq_req[REQ_DED]);
	c_grp: cover property (irq_req[2]);
	c_wake: cover property (wake_req);
	c_ack: cover property (irq_ack[2] && irq_req[2]);
endmodule : epi_unit_monitor

bind epi_unit epi_unit_monitor chk_u (
	.hclk              (hclk),
	.hresetn           (hresetn),
	.hsel              (hsel),
	.haddr             (haddr),
	.htrans            (htrans),
	.hwrite            (hwrite),
	.hready            (hready),
	.hwdata            (hwdata),
	.dedicated_irq_pin (dedicated_irq_pin),
	.pin_change_inputs (pin_change_inputs),
	.global_irq_en     (global_irq_en),
	.irq_ack           (irq_ack),
	.irq_req           (irq_req),
	.irq               (irq),
	.sleep_active      (sleep_active),
	.startup_done      (startup_done),
	.wake_req          (wake_req)
);

`default_nettype wire

// [tb_top.sv]
// Self-checking bench of the external pin interrupt unit
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import epi_pkg::*;
;
	logic	hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, wake_req;
	logic	global_irq_en, sleep_active, sleep_idle, startup_done, dedicated_irq_pin;
	logic [1:0]	htrans;
	logic [2:0]	hsize;
	logic [31:0]	haddr, hwdata, hrdata, rd;
	logic [NUM_PC-1:0]	pin_change_inputs;
	logic [NUM_REQ-1:0]	irq_ack, irq_req;
	int	n_fail = 0;
	int	samples_checked = 0;
	// Rows: pin, mask offset, mask value, expected flags
	logic [31:0]	rows [5] = '{32'h030c_0810, 32'h030c_f700, 32'h0c10_1020, 32'h1414_1040, 32'h1e18_4080};

	epi_unit dut_u (
		.hclk              (hclk),
		.hresetn           (hresetn),
		.hsel              (hsel),
		.haddr             (haddr),
		.htrans            (htrans),
		.hwrite            (hwrite),
		.hsize             (hsize),
		.hready            (hreadyout),
		.hwdata            (hwdata),
		.hreadyout         (hreadyout),
		.hresp             (hresp),
		.hrdata            (hrdata),
		.dedicated_irq_pin (dedicated_irq_pin),
		.pin_change_inputs (pin_change_inputs),
		.global_irq_en     (global_irq_en),
		.irq_ack           (irq_ack),
		.irq_req           (irq_req),
		.irq               (irq),
		.sleep_active      (sleep_active),
		.sleep_idle        (sleep_idle),
		.startup_done      (startup_done),
		.wake_req          (wake_req)
	);
	epi_src_model src_u (.hclk(hclk), .ded(dedicated_irq_pin), .pc(pin_change_inputs));

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		hsize <= 3'h2;
		// Writes go through an upper-address alias, which the slave ignores
		haddr <= {{24{w}}, a};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, rd);
		chk(rd, e);
		chk({30'h0, hresp, hreadyout}, {30'h0, HRESP_OKAY, 1'b1});
	endtask : rdc

	task automatic settle();
		repeat (6) @(posedge hclk);
	endtask : settle

	task automatic report_and_stop();
		$display("checks=%0d fails=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	initial begin
		#50us;
		n_fail++;
		report_and_stop();
	end

	initial begin
		{hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata, irq_ack, sleep_active, sleep_idle} = '0;
		{global_irq_en, startup_done} = 2'b11;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		// Reset values, pins word and an unmapped word
		for (int i = 0; i < 9; i++) rdc(8'(i * 4), i == 7 ? 32'h8000_0000 : 32'h0);
		chk({31'h0, wake_req}, 32'h0);
		bus(1'b1, OFS_MASK3, 32'hff, rd);
		rdc(OFS_MASK3, {24'h0, MASK3_USED});
		bus(1'b1, OFS_ENABLE, 32'hffff_fff0, rd);
		foreach (rows[k]) begin
			bus(1'b1, rows[k][23:16], {24'h0, rows[k][15:8]}, rd);
			src_u.flip(rows[k][31:24]);
			settle();
			chk({27'h0, irq_req}, {27'h0, rows[k][7:4], 1'b0});
			rdc(OFS_FLAG, {24'h0, rows[k][7:0]});
			bus(1'b1, OFS_FLAG, 32'hff, rd);
			rdc(OFS_FLAG, 32'h0);
		end
		// Handler entry clears only the acknowledged group flags
		src_u.flip(0);
		src_u.flip(12);
		src_u.flip(20);
		src_u.flip(30);
		settle();
		chk({27'h0, irq_req}, 32'h1e);
		irq_ack <= 5'h0a;
		@(posedge hclk);
		irq_ack <= 5'h00;
		settle();
		chk({27'h0, irq_req}, 32'h14);
		irq_ack <= 5'h15;
		@(posedge hclk);
		irq_ack <= 5'h00;
		settle();
		chk({27'h0, irq_req}, 32'h0);
		// Edge modes on the dedicated pin
		bus(1'b1, OFS_ENABLE, 32'h01, rd);
		for (int m = 1; m < 4; m++) begin
			bus(1'b1, OFS_SENSE, 32'(m), rd);
			bus(1'b1, OFS_FLAG, 32'h1, rd);
			src_u.lvl(1'b0);
			settle();
			rdc(OFS_FLAG, {31'h0, m != 3});
			bus(1'b1, OFS_FLAG, 32'h1, rd);
			src_u.lvl(1'b1);
			settle();
			chk({31'h0, irq_req[REQ_DED]}, {31'h0, m != 2});
		end
		// Level mode, global enable, start-up and wake
		bus(1'b1, OFS_SENSE, SENSE_LOW, rd);
		src_u.lvl(1'b0);
		settle();
		chk({31'h0, irq}, 32'h1);
		rdc(OFS_FLAG, 32'h0);
		global_irq_en <= 1'b0;
		settle();
		chk({31'h0, irq}, 32'h0);
		{global_irq_en, startup_done} <= 2'b10;
		settle();
		chk({31'h0, irq}, 32'h0);
		{startup_done, sleep_active} <= 2'b11;
		settle();
		chk({31'h0, wake_req}, 32'h1);
		// Edges ignored in deep sleep, seen in idle sleep
		src_u.lvl(1'b1);
		bus(1'b1, OFS_SENSE, SENSE_FALL, rd);
		src_u.lvl(1'b0);
		settle();
		rdc(OFS_FLAG, 32'h0);
		sleep_idle <= 1'b1;
		src_u.lvl(1'b1);
		settle();
		src_u.lvl(1'b0);
		settle();
		rdc(OFS_FLAG, 32'h1);
		// Pin change wakes from deep sleep; the group flag still sets
		bus(1'b1, OFS_ENABLE, 32'h10, rd);
		sleep_idle <= 1'b0;
		src_u.flip(0);
		@(posedge hclk);
		chk({31'h0, wake_req}, 32'h1);
		settle();
		chk({31'h0, wake_req}, 32'h0);
		rdc(OFS_FLAG, 32'h11);
		// Reset in mid-run returns the registers to their reset values
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(OFS_SENSE, 32'h0);
		rdc(OFS_ENABLE, 32'h0);
		rdc(OFS_FLAG, 32'h0);
		chk({31'h0, irq}, 32'h0);
		report_and_stop();
	end
endmodule : tb_top

`default_nettype wire
